// >>> osc_ctrl_defs.vh
// Offsets, field positions, reset values and timing counts of the clock-source controller
`ifndef OSC_CTRL_DEFS_VH
`define OSC_CTRL_DEFS_VH
// Register indices, byte address is four times the index
`define SLEEP_STAT_IDX      12'h0be
`define CLOCK_CTRL_IDX      12'h0c6
// Status and power-down register fields
`define FLD_XTAL_STB        6
`define FLD_FRC_STB         5
`define FLD_OSC_PD          2
`define FLD_MODE_HI         1
`define FLD_MODE_LO         0
// Clock control register fields
`define FLD_SLOW_SEL        7
`define FLD_SYS_SEL         6
`define FLD_SPD_HI          2
`define FLD_SPD_LO          0
// Reset values
`define RST_OSC_PD          1'b1
`define RST_MODE            2'h0
`define RST_SLOW_SEL        1'b1
`define RST_SYS_SEL         1'b1
`define RST_CLK_SPD         3'h1
`define RST_FRC_TRIM        8'h80
// Timing
`define CLK_MHZ             250
`define LPRC_CAL_TIME_US    2000
`define ABORT_DELAY_US      130
`define FRC_CAL_TIME_US     4
`define LPRC_CAL_CYCLES     (`LPRC_CAL_TIME_US * `CLK_MHZ)
`define ABORT_DELAY_CYCLES  (`ABORT_DELAY_US * `CLK_MHZ)
`define FRC_CAL_CYCLES      (`FRC_CAL_TIME_US * `CLK_MHZ)
`define TIMER_W             20
// Slow RC target divide ratios of the crystal clock
`define LPRC_DIV_PLAIN      11'h2ee
`define LPRC_DIV_USB        11'h5dc
// Data-rate caps in kBaud
`define RATE_500            10'h1f4
`define RATE_400            10'h190
`define RATE_250            10'h0fa
`define RATE_200            10'h0c8
`define RATE_100            10'h064
`define RATE_50             10'h032
`endif

// >>> cal_timer.v
// One-shot cycle timer used for calibration runs and abort delays
`timescale 1ns/10ps
`include "osc_ctrl_defs.vh"
module cal_timer (
  input  wire                hclk,
  input  wire                hresetn,
  input  wire                start,
  input  wire                stop,
  input  wire [`TIMER_W-1:0] load,
  output reg                 busy_ff,
  output reg                 done_ff
);
  reg [`TIMER_W-1:0] cnt_ff;

  // Stop wins over start; done pulses one cycle at the end of a full run
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_ff  <= {`TIMER_W{1'b0}};
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (stop) begin
        busy_ff <= 1'b0;
      end else if (start && !busy_ff) begin
        cnt_ff  <= load;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        if (cnt_ff <= {{(`TIMER_W-1){1'b0}}, 1'b1}) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - {{(`TIMER_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // cal_timer

// >>> osc_select_and_rc_calibration.v
// Clock-source selection and RC oscillator calibration sequencer with AHB-Lite registers
// Notes on behaviour
// [R1] System clock is fast RC or crystal; USB variant halves 48 MHz crystal to 24 MHz.
// [R2] Slow source select 0 picks 32.768 kHz crystal, 1 picks slow RC.
// [R3] Current system clock stays until the new fast oscillator reports stable.
// [R4] Software must not rewrite the system source select until the change completes.
// [R5] Crystal-to-RC switch waits for running calibration even after RC stable.
// [R6] Power-down 1 stops the unselected fast oscillator; 0 keeps both running.
// [R7] Toggling the system source select clears the power-down bit.
// [R8] Software sets power-down only after the selected oscillator reports stable.
// [R9] Selecting crystal starts one fast RC calibration; blocks sleep, RC switch, RC power-down.
// [R10] After calibration fast RC keeps trim; powered down it reuses stored trim later.
// [R11] Crystal selected at sleep entry: fast RC recalibrates after wake once crystal stable.
// [R12] Waking from the two deepest modes restores the default fast RC trim.
// [R13] Software uses stable crystal as system clock before operating the radio.
// [R14] Software programs divider 000 whenever radio error correction is enabled.
// [R15] Clock speed divider caps radio data rate per the fixed table.
// [R16] Calibrated slow RC runs at crystal over 750, or 1500 on USB variant.
// [R17] Slow RC calibration needs RC and stable crystal; repeats while crystal clocks awake.
// [R18] Only one slow oscillator runs; after reset slow RC is enabled and selected.
// [R19] Software changes slow source select only while fast RC is system clock.
// [R20] Slow RC calibration takes 2 ms; later runs abort on RC switch or sleep.
// [R21] Requests during initial calibration wait for it; later ones abort after 130 us.
// [R22] Software issues one request during initial calibration, none within 130 us after.
// [R23] Crystal-stable and RC-stable flags are readable status at any time.
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/10ps
`include "osc_ctrl_defs.vh"
module osc_select_and_rc_calibration #(
  parameter USB_VARIANT        = 0,
  parameter LPRC_CAL_CYCLES    = `LPRC_CAL_CYCLES,
  parameter ABORT_DELAY_CYCLES = `ABORT_DELAY_CYCLES,
  parameter FRC_CAL_CYCLES     = `FRC_CAL_CYCLES
) (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata_ff,
  output reg         hreadyout_ff,
  output reg         hresp_ff,
  input  wire        crystal_stable_flag,
  input  wire        fast_rc_stable_flag,
  input  wire        sleep_enter,
  input  wire        wake_up,
  input  wire [7:0]  fast_rc_trim_measured,
  output reg         sysclk_on_rc_ff,
  output reg         crystal_power_en_ff,
  output reg         fast_rc_power_en_ff,
  output reg         sysclk_crystal_halved_ff,
  output reg         usb_clock_en_ff,
  output reg         slow_crystal_en_ff,
  output reg         slow_rc_en_ff,
  output reg  [7:0]  fast_rc_trim_ff,
  output reg  [10:0] slow_rc_divide_ff,
  output reg         slow_rc_calibrated_ff,
  output reg         in_sleep_ff,
  output reg  [1:0]  sleep_mode_ff,
  output reg         fast_rc_cal_busy_ff,
  output reg         slow_rc_cal_busy_ff,
  output reg  [9:0]  rate_cap_ff,
  output reg  [9:0]  gfsk_rate_cap_ff
);
  // Sequencer states
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_WAIT  = 3'b010;
  localparam [2:0] ST_ABORT = 3'b100;

  reg        sys_sel_ff;      // Requested source, 1 selects fast RC
  reg        sys_src_ff;      // Source actually in use
  reg        slow_sel_ff;
  reg        osc_pd_ff;
  reg        pd_pend_ff;
  reg [1:0]  mode_ff;
  reg [2:0]  clk_spd_ff;
  reg        sleep_pend_ff;
  reg        lprc_init_ff;
  reg        frc_recal_ff;
  reg [2:0]  state_ff;
  reg [2:0]  nxt_state;
  reg        wr_pend_ff;
  reg        rd_pend_ff;
  reg [11:0] idx_ff;
  reg [7:0]  rd_byte;
  wire       frc_busy;
  wire       frc_done;
  wire       lprc_busy;
  wire       lprc_done;
  wire       abort_done;

  // Bus decode
  wire       access  = hsel && hready && htrans[1];
  wire       sel_idx = (haddr[1:0] == 2'h0);
  wire [7:0] wbyte   = hwdata[7:0];
  wire       wr_slp  = wr_pend_ff && (idx_ff == `SLEEP_STAT_IDX);
  wire       wr_clk  = wr_pend_ff && (idx_ff == `CLOCK_CTRL_IDX);
  wire       sel_tgl = wr_clk && (wbyte[`FLD_SYS_SEL] != sys_sel_ff);

  // Pending leave actions and their gating
  wire rc_pend    = sys_sel_ff && !sys_src_ff;
  wire leave_pend = rc_pend || sleep_pend_ff;
  wire frc_block  = frc_busy || frc_recal_ff;                            // see [R9]
  wire do_leave   = (state_ff == ST_WAIT && !frc_block && !lprc_busy)
                  || (state_ff == ST_ABORT && abort_done);
  wire do_rc      = do_leave && rc_pend && fast_rc_stable_flag;          // see [R3] see [R5]
  wire do_sleep   = do_leave && !rc_pend && sleep_pend_ff;
  wire do_xtal    = !sys_sel_ff && sys_src_ff && crystal_stable_flag;    // see [R3]
  wire wake       = wake_up && in_sleep_ff;

  // Calibration starts and aborts
  wire frc_start  = do_xtal || (frc_recal_ff && !in_sleep_ff && !sys_src_ff
                  && crystal_stable_flag);                               // see [R9] see [R11]
  wire lprc_ok    = !sys_src_ff && !in_sleep_ff && slow_sel_ff && crystal_stable_flag;
  wire lprc_start = lprc_ok && !lprc_busy && state_ff != ST_ABORT && !leave_pend; // see [R17]
  wire lprc_stop  = (state_ff == ST_ABORT && abort_done) || !lprc_ok;   // see [R20]
  wire abort_go   = state_ff == ST_WAIT && !frc_block && lprc_busy && !lprc_init_ff; // see [R21]

  // Sequencer for switch-to-RC and sleep requests
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:  if (leave_pend) nxt_state = ST_WAIT;
      ST_WAIT:  begin
        if (abort_go) nxt_state = ST_ABORT;                              // see [R21]
        else if (do_rc || do_sleep || !leave_pend) nxt_state = ST_IDLE;
      end
      ST_ABORT: if (abort_done) nxt_state = ST_WAIT;
      default:  nxt_state = ST_IDLE;
    endcase
  end

  cal_timer u_frc_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (frc_start),
    .stop    (1'b0),
    .load    (FRC_CAL_CYCLES[`TIMER_W-1:0]),
    .busy_ff (frc_busy),
    .done_ff (frc_done)
  );

  cal_timer u_lprc_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (lprc_start),
    .stop    (lprc_stop),
    .load    (LPRC_CAL_CYCLES[`TIMER_W-1:0]),
    .busy_ff (lprc_busy),
    .done_ff (lprc_done)
  );

  cal_timer u_abort_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (abort_go),
    .stop    (1'b0),
    .load    (ABORT_DELAY_CYCLES[`TIMER_W-1:0]),
    .busy_ff (),
    .done_ff (abort_done)
  );

  // Register read mux
  always @* begin
    rd_byte = 8'h00;
    case (idx_ff)
      `SLEEP_STAT_IDX: begin
        rd_byte[`FLD_XTAL_STB] = crystal_stable_flag;                    // see [R23]
        rd_byte[`FLD_FRC_STB]  = fast_rc_stable_flag;                    // see [R23]
        rd_byte[`FLD_OSC_PD]   = osc_pd_ff;
        rd_byte[`FLD_MODE_HI:`FLD_MODE_LO] = mode_ff;
      end
      `CLOCK_CTRL_IDX: begin
        rd_byte[`FLD_SLOW_SEL] = slow_sel_ff;
        rd_byte[`FLD_SYS_SEL]  = sys_src_ff;
        rd_byte[`FLD_SPD_HI:`FLD_SPD_LO] = clk_spd_ff;
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // AHB-Lite slave: writes take no wait state, reads take one
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      hrdata_ff    <= 32'h0000_0000;
      wr_pend_ff   <= 1'b0;
      rd_pend_ff   <= 1'b0;
      idx_ff       <= 12'h000;
    end else begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      if (rd_pend_ff) begin
        hrdata_ff    <= {24'h00_0000, rd_byte};
        hreadyout_ff <= 1'b1;
      end else if (access) begin
        idx_ff       <= sel_idx ? haddr[13:2] : 12'hfff;
        wr_pend_ff   <= hwrite;
        rd_pend_ff   <= !hwrite;
        hreadyout_ff <= hwrite;
      end
    end
  end

  // Clock-source control state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sys_sel_ff    <= `RST_SYS_SEL;
      sys_src_ff    <= `RST_SYS_SEL;
      slow_sel_ff   <= `RST_SLOW_SEL;                                    // see [R18]
      osc_pd_ff     <= `RST_OSC_PD;
      pd_pend_ff    <= 1'b0;
      mode_ff       <= `RST_MODE;
      clk_spd_ff    <= `RST_CLK_SPD;
      sleep_pend_ff <= 1'b0;
      lprc_init_ff  <= 1'b0;
      frc_recal_ff  <= 1'b0;
      state_ff      <= ST_IDLE;
      in_sleep_ff   <= 1'b0;
      sleep_mode_ff <= 2'h0;
      fast_rc_trim_ff       <= `RST_FRC_TRIM;
      slow_rc_calibrated_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (wr_clk) begin
        sys_sel_ff <= wbyte[`FLD_SYS_SEL];
        slow_sel_ff <= wbyte[`FLD_SLOW_SEL];                             // see [R2]
        clk_spd_ff <= wbyte[`FLD_SPD_HI:`FLD_SPD_LO];
      end
      // Power-down: a toggle clears it, a set during calibration is deferred
      if (sel_tgl) begin
        osc_pd_ff  <= 1'b0;                                              // see [R7]
        pd_pend_ff <= 1'b0;
      end else if (wr_slp) begin
        if (!wbyte[`FLD_OSC_PD]) begin
          osc_pd_ff  <= 1'b0;
          pd_pend_ff <= 1'b0;
        end else if (frc_busy || lprc_busy) begin
          pd_pend_ff <= 1'b1;
        end else begin
          osc_pd_ff <= 1'b1;
        end
      end else if (pd_pend_ff && !frc_busy && !lprc_busy) begin
        osc_pd_ff  <= 1'b1;
        pd_pend_ff <= 1'b0;
      end
      // Mode bits clear on sleep entry
      if (do_sleep) mode_ff <= 2'h0;
      else if (wr_slp) mode_ff <= wbyte[`FLD_MODE_HI:`FLD_MODE_LO];
      // Source switching
      if (do_xtal) begin
        sys_src_ff   <= 1'b0;
        lprc_init_ff <= 1'b1;                                            // see [R21]
      end else if (do_rc) begin
        sys_src_ff <= 1'b1;                                              // see [R5]
      end
      if (lprc_done) begin
        lprc_init_ff          <= 1'b0;
        slow_rc_calibrated_ff <= 1'b1;                                   // see [R16]
      end
      // Sleep entry and wake-up
      if (do_sleep) begin
        sleep_pend_ff <= 1'b0;
        in_sleep_ff   <= 1'b1;
        sleep_mode_ff <= mode_ff;
        frc_recal_ff  <= !sys_src_ff;                                    // see [R11]
      end else if (sleep_enter && !in_sleep_ff) begin
        sleep_pend_ff <= 1'b1;
      end
      // A recalibration request is consumed by its start, unless a sleep entry in the same cycle sets it anew
      if (frc_start && !do_sleep) begin
        frc_recal_ff <= 1'b0;
      end
      if (wake) begin
        in_sleep_ff <= 1'b0;
        if (sleep_mode_ff[1]) begin
          fast_rc_trim_ff <= `RST_FRC_TRIM;                              // see [R12]
          slow_sel_ff     <= `RST_SLOW_SEL;
        end
      end else if (frc_done) begin
        fast_rc_trim_ff <= fast_rc_trim_measured;                        // see [R10]
      end
    end
  end

  // Oscillator enables and rate caps, all registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sysclk_on_rc_ff          <= `RST_SYS_SEL;
      crystal_power_en_ff      <= 1'b0;
      fast_rc_power_en_ff      <= 1'b1;
      sysclk_crystal_halved_ff <= 1'b0;
      usb_clock_en_ff          <= 1'b0;
      slow_crystal_en_ff       <= 1'b0;
      slow_rc_en_ff            <= 1'b1;
      slow_rc_divide_ff        <= 11'h000;
      fast_rc_cal_busy_ff      <= 1'b0;
      slow_rc_cal_busy_ff      <= 1'b0;
      rate_cap_ff              <= `RATE_500;
      gfsk_rate_cap_ff         <= `RATE_250;
    end else begin
      sysclk_on_rc_ff     <= sys_src_ff;                                 // see [R1]
      crystal_power_en_ff <= !osc_pd_ff || !sys_src_ff || !sys_sel_ff || lprc_busy;     // see [R6]
      fast_rc_power_en_ff <= !osc_pd_ff || sys_src_ff || sys_sel_ff || frc_busy;        // see [R6] see [R9]
      sysclk_crystal_halved_ff <= (USB_VARIANT != 0) && !sys_src_ff;    // see [R1]
      usb_clock_en_ff     <= (USB_VARIANT != 0) && crystal_stable_flag;
      slow_crystal_en_ff  <= !slow_sel_ff;                               // see [R18]
      slow_rc_en_ff       <= slow_sel_ff;                                // see [R18]
      slow_rc_divide_ff   <= (USB_VARIANT != 0) ? `LPRC_DIV_USB : `LPRC_DIV_PLAIN; // see [R16]
      fast_rc_cal_busy_ff <= frc_busy;
      slow_rc_cal_busy_ff <= lprc_busy;
      case (clk_spd_ff)                                                  // see [R15]
        3'h4:    begin rate_cap_ff <= `RATE_400; gfsk_rate_cap_ff <= `RATE_250; end
        3'h5:    begin rate_cap_ff <= `RATE_200; gfsk_rate_cap_ff <= `RATE_200; end
        3'h6:    begin rate_cap_ff <= `RATE_100; gfsk_rate_cap_ff <= `RATE_100; end
        3'h7:    begin rate_cap_ff <= `RATE_50;  gfsk_rate_cap_ff <= `RATE_50;  end
        default: begin rate_cap_ff <= `RATE_500; gfsk_rate_cap_ff <= `RATE_250; end
      endcase
    end
  end
endmodule // osc_select_and_rc_calibration

// >>> osc_ctrl_properties.sv
// Concurrent checks on the ports of the clock-source controller
`timescale 1ns/10ps
module osc_ctrl_properties #(
  parameter USB_VARIANT = 0
) (
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout_ff,
  input wire        crystal_stable_flag,
  input wire        fast_rc_stable_flag,
  input wire        sysclk_on_rc_ff,
  input wire        crystal_power_en_ff,
  input wire        fast_rc_power_en_ff,
  input wire        sysclk_crystal_halved_ff,
  input wire        usb_clock_en_ff,
  input wire        slow_crystal_en_ff,
  input wire        slow_rc_en_ff,
  input wire [7:0]  fast_rc_trim_ff,
  input wire [10:0] slow_rc_divide_ff,
  input wire        slow_rc_calibrated_ff,
  input wire        in_sleep_ff,
  input wire [1:0]  sleep_mode_ff,
  input wire        fast_rc_cal_busy_ff,
  input wire        slow_rc_cal_busy_ff,
  input wire [9:0]  rate_cap_ff,
  input wire [9:0]  gfsk_rate_cap_ff
);
  localparam int DIV = (USB_VARIANT != 0) ? 1500 : 750;
  // All checks share the bus clock and reset
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_slow_one;
    slow_crystal_en_ff != slow_rc_en_ff;
  endproperty
  a_slow_one: assert property (p_slow_one) else $error("slow oscillator enables not exclusive");
  property p_divide;
    slow_rc_calibrated_ff |-> slow_rc_divide_ff == DIV;
  endproperty
  a_divide: assert property (p_divide) else $error("slow RC divide ratio wrong");
  property p_caps;
    rate_cap_ff inside {10'h1f4, 10'h190, 10'h0c8, 10'h064, 10'h032} &&
    gfsk_rate_cap_ff == ((rate_cap_ff > 10'h0fa) ? 10'h0fa : rate_cap_ff);
  endproperty
  a_caps: assert property (p_caps) else $error("rate caps inconsistent");
  property p_to_xtal;
    $fell(sysclk_on_rc_ff) |-> $past(crystal_stable_flag);
  endproperty
  a_to_xtal: assert property (p_to_xtal) else $error("switch to unstable crystal");
  property p_to_rc;
    $rose(sysclk_on_rc_ff) |-> $past(fast_rc_stable_flag) && !$past(fast_rc_cal_busy_ff, 2);
  endproperty
  a_to_rc: assert property (p_to_rc) else $error("switch to RC too early");
  property p_sel_powered;
    sysclk_on_rc_ff ? fast_rc_power_en_ff : crystal_power_en_ff;
  endproperty
  a_sel_powered: assert property (p_sel_powered) else $error("selected oscillator unpowered");
  property p_read_wait;
    hsel && hready && htrans[1] && !hwrite |=> !hreadyout_ff ##1 hreadyout_ff;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
  property p_no_usb;
    USB_VARIANT == 0 |-> !usb_clock_en_ff && !sysclk_crystal_halved_ff;
  endproperty
  a_no_usb: assert property (p_no_usb) else $error("USB clocking on plain variant");
  property p_slow_cal_xtal;
    slow_rc_cal_busy_ff && $past(slow_rc_cal_busy_ff, 2) |-> crystal_power_en_ff;
  endproperty
  a_slow_cal_xtal: assert property (p_slow_cal_xtal) else $error("slow cal without crystal");
  property p_wake_trim;
    $fell(in_sleep_ff) && $past(sleep_mode_ff[1]) |-> ##[0:2] fast_rc_trim_ff == 8'h80;
  endproperty
  a_wake_trim: assert property (p_wake_trim) else $error("trim not restored on wake");
endmodule // osc_ctrl_properties

bind osc_select_and_rc_calibration osc_ctrl_properties #(.USB_VARIANT(USB_VARIANT)) chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout_ff(hreadyout_ff), .crystal_stable_flag(crystal_stable_flag),
  .fast_rc_stable_flag(fast_rc_stable_flag), .sysclk_on_rc_ff(sysclk_on_rc_ff),
  .crystal_power_en_ff(crystal_power_en_ff), .fast_rc_power_en_ff(fast_rc_power_en_ff),
  .sysclk_crystal_halved_ff(sysclk_crystal_halved_ff), .usb_clock_en_ff(usb_clock_en_ff),
  .slow_crystal_en_ff(slow_crystal_en_ff), .slow_rc_en_ff(slow_rc_en_ff), .fast_rc_trim_ff(fast_rc_trim_ff),
  .slow_rc_divide_ff(slow_rc_divide_ff), .slow_rc_calibrated_ff(slow_rc_calibrated_ff),
  .in_sleep_ff(in_sleep_ff), .sleep_mode_ff(sleep_mode_ff), .fast_rc_cal_busy_ff(fast_rc_cal_busy_ff),
  .slow_rc_cal_busy_ff(slow_rc_cal_busy_ff), .rate_cap_ff(rate_cap_ff), .gfsk_rate_cap_ff(gfsk_rate_cap_ff)
);

// >>> test_osc_select_and_rc_calibration.sv
// Register-level testbench of the clock-source controller
`timescale 1ns/10ps
module test_osc_select_and_rc_calibration;
  localparam logic [31:0] SLP = 32'h0000_02f8;
  localparam logic [31:0] CKC = 32'h0000_0318;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        crystal_stable_flag = 1'b0, fast_rc_stable_flag = 1'b1;
  logic        sleep_enter = 1'b0, wake_up = 1'b0;
  logic [7:0]  trim_meas = 8'h5a;
  wire  [31:0] hrdata_ff;
  wire         hreadyout_ff, hresp_ff, sysclk_on_rc_ff, crystal_power_en_ff, fast_rc_power_en_ff;
  wire         slow_rc_calibrated_ff, in_sleep_ff, fast_rc_cal_busy_ff, slow_rc_cal_busy_ff;
  wire         slow_crystal_en_ff, slow_rc_en_ff;
  wire  [7:0]  fast_rc_trim_ff;
  wire  [10:0] slow_rc_divide_ff;
  wire  [1:0]  sleep_mode_ff;
  wire  [9:0]  rate_cap_ff, gfsk_rate_cap_ff;
  logic [9:0]  caps [0:7] = '{10'h1f4, 10'h1f4, 10'h1f4, 10'h1f4, 10'h190, 10'h0c8, 10'h064, 10'h032};
  logic [9:0]  gcap [0:7] = '{10'h0fa, 10'h0fa, 10'h0fa, 10'h0fa, 10'h0fa, 10'h0c8, 10'h064, 10'h032};
  int          err_total = 0, samples_checked = 0, i, n;

  osc_select_and_rc_calibration #(.LPRC_CAL_CYCLES(50), .ABORT_DELAY_CYCLES(20), .FRC_CAL_CYCLES(10)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout_ff), .hrdata_ff(hrdata_ff),
    .hreadyout_ff(hreadyout_ff), .hresp_ff(hresp_ff), .crystal_stable_flag(crystal_stable_flag),
    .fast_rc_stable_flag(fast_rc_stable_flag), .sleep_enter(sleep_enter), .wake_up(wake_up),
    .fast_rc_trim_measured(trim_meas), .sysclk_on_rc_ff(sysclk_on_rc_ff),
    .crystal_power_en_ff(crystal_power_en_ff), .fast_rc_power_en_ff(fast_rc_power_en_ff),
    .sysclk_crystal_halved_ff(), .usb_clock_en_ff(), .slow_crystal_en_ff(slow_crystal_en_ff),
    .slow_rc_en_ff(slow_rc_en_ff), .fast_rc_trim_ff(fast_rc_trim_ff), .slow_rc_divide_ff(slow_rc_divide_ff),
    .slow_rc_calibrated_ff(slow_rc_calibrated_ff), .in_sleep_ff(in_sleep_ff), .sleep_mode_ff(sleep_mode_ff),
    .fast_rc_cal_busy_ff(fast_rc_cal_busy_ff), .slow_rc_cal_busy_ff(slow_rc_cal_busy_ff),
    .rate_cap_ff(rate_cap_ff), .gfsk_rate_cap_ff(gfsk_rate_cap_ff)
  );

  // Free-running bus clock
  initial begin
    forever #2 hclk = ~hclk;
  end

  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer, waiting on ready in both phases
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do begin @(posedge hclk); end while (hreadyout_ff !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do begin @(posedge hclk); end while (hreadyout_ff !== 1'b1);
    rd = hrdata_ff;
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task rchk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, exp);
  endtask

  function logic sig(input int s);
    case (s)
      0: return sysclk_on_rc_ff;
      1: return in_sleep_ff;
      2: return fast_rc_cal_busy_ff;
      default: return slow_rc_cal_busy_ff;
    endcase
  endfunction

  // Bounded wait for a status output to reach a level
  task wait_on(input int s, input logic v, input int lim);
    int k;
    k = 0;
    while (sig(s) !== v && k < lim) begin
      @(posedge hclk);
      k++;
    end
    check(k < lim, 1);
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Hang guard, far beyond the expected run length
  initial begin
    #40000;
    err_total++;
    complete_run;
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(SLP, 32'h24);
    rchk(CKC, 32'hc1);
    rchk(32'h100, 32'h0);
    check(hresp_ff, 1'b0);
    check(slow_rc_en_ff, 1);
    check(fast_rc_trim_ff, 8'h80);
    $display("test reset values done");
    for (i = 0; i < 8; i++) begin
      wr(CKC, 32'hc0 | i);
      repeat (2) @(posedge hclk);
      check(rate_cap_ff, caps[i]);
      check(gfsk_rate_cap_ff, gcap[i]);
    end
    $display("test divider caps done");
    wr(CKC, 32'h81);
    rchk(SLP, 32'h20);
    repeat (20) @(posedge hclk);
    check(sysclk_on_rc_ff, 1);
    rchk(CKC, 32'hc1);
    crystal_stable_flag <= 1'b1;
    wait_on(0, 1'b0, 20);
    wait_on(2, 1'b1, 5);
    wait_on(3, 1'b1, 5);
    wait_on(2, 1'b0, 30);
    repeat (2) @(posedge hclk);
    check(fast_rc_trim_ff, 8'h5a);
    check(crystal_power_en_ff & fast_rc_power_en_ff, 1);
    $display("test crystal select done");
    fast_rc_stable_flag <= 1'b0;
    wr(CKC, 32'hc1);
    check(sysclk_on_rc_ff, 0);
    repeat (40) @(posedge hclk);
    check(sysclk_on_rc_ff, 0);
    fast_rc_stable_flag <= 1'b1;
    wait_on(0, 1'b1, 20);
    check(slow_rc_calibrated_ff, 1);
    check(slow_rc_divide_ff, 11'h2ee);
    wr(SLP, 32'h04);
    repeat (3) @(posedge hclk);
    check({crystal_power_en_ff, fast_rc_power_en_ff}, 2'b01);
    $display("test return to RC done");
    wr(CKC, 32'h81);
    wait_on(0, 1'b0, 20);
    repeat (70) @(posedge hclk);
    wait_on(3, 1'b1, 5);
    wr(CKC, 32'hc1);
    for (n = 0; sysclk_on_rc_ff !== 1'b1 && n < 60; n++) @(posedge hclk);
    check(n >= 20 && n <= 27, 1);
    $display("test calibration abort done");
    wr(SLP, 32'h06);
    sleep_enter <= 1'b1;
    @(posedge hclk);
    sleep_enter <= 1'b0;
    wait_on(1, 1'b1, 20);
    rchk(SLP, 32'h64);
    check(sleep_mode_ff, 2'h2);
    wake_up <= 1'b1;
    @(posedge hclk);
    wake_up <= 1'b0;
    wait_on(1, 1'b0, 20);
    repeat (3) @(posedge hclk);
    check(fast_rc_trim_ff, 8'h80);
    $display("test sleep and wake done");
    complete_run;
  end
endmodule // test_osc_select_and_rc_calibration
